// [core/hub_interrupt_connect_control.sv]
// sideband control of the hub: attach stage sequencing, clock strap capture,
// latched event interrupt with mask, and suspend level indication.
// assumes a serial port engine in front issues one-cycle register requests,
// and all inputs are synchronous to clock.
//
// Operation
// - hub enters communication stage when attach request is high
// - attach low: stay waiting until software clears connect hold bit
// - attach tied high: enter communication stage, ignoring connect hold bit
// - low to high attach transition moves hub into communication stage
// - logic acts only on rising clock edge; duty cycle irrelevant
// - straps: 00=38.4, 01=26.0, 10=19.2, 11=12.0 MHz; system matches clock
// - every interrupt condition is recorded in status register at E8h
// - mask register at E9h selects which recorded conditions drive interrupt
// - status bit stays set until software clears it, even if condition ends
// - cleared bit sets again only after condition goes away and reappears
// - suspend indication select turns interrupt into configuration/suspend level
// - level mode signals whole-hub suspend so system cuts bus power draw
// - level mode ignores selective suspend of individual downstream ports
// - general mode pulls interrupt low on enabled status; releases after clear
// - level mode: low while unconfigured or suspended, released while active
// - straps captured once during initialisation and held afterwards
`timescale 1ns/1ns
`include "hub_sideband_consts.svh"

module hub_interrupt_connect_control (
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	input  wire logic                         attach_request,
	input  wire logic [1:0]                   ref_select_strap,
	input  wire hub_sideband_pkg::event_vec_t event_conditions,
	input  wire logic                         hub_configured,
	input  wire logic                         hub_suspended,
	input  wire hub_sideband_pkg::reg_req_s   reg_req,
	output logic [7:0]                        reg_rdata,
	output logic [1:0]                        ref_frequency_select,
	output logic                              comm_stage,
	output logic                              int_pin_out,
	output logic                              int_pin_oe
);

	hub_sideband_pkg::hub_stage_e stage;
	hub_sideband_pkg::hub_stage_e next_stage;
	hub_sideband_pkg::event_vec_t interrupt_event_status;
	hub_sideband_pkg::event_vec_t interrupt_event_mask;
	hub_sideband_pkg::event_vec_t next_status;
	hub_sideband_pkg::event_vec_t condition_last;
	logic [7:0]                   interlock_register;
	logic [7:0]                   sideband_cfg;

	// register decode
	wire hit_status    = reg_req.addr == `EVENT_STATUS_ADDR;
	wire hit_mask      = reg_req.addr == `EVENT_MASK_ADDR;
	wire hit_interlock = reg_req.addr == `INTERLOCK_ADDR;
	wire hit_cfg       = reg_req.addr == `SIDEBAND_CFG_ADDR;
	wire status_clear  = reg_req.write && hit_status;
	wire write_mask      = reg_req.write && hit_mask;
	wire write_interlock = reg_req.write && hit_interlock;
	wire write_cfg       = reg_req.write && hit_cfg;
	wire connect_hold  = interlock_register[`CONNECT_HOLD_BIT];
	wire suspend_indication_select = sideband_cfg[`SUSPEND_SELECT_BIT];

	wire [7:0] read_mux =
		hit_status    ? interrupt_event_status :
		hit_mask      ? interrupt_event_mask :
		hit_interlock ? interlock_register :
		hit_cfg       ? sideband_cfg : `READ_DATA_RESET;
	wire [7:0] next_rdata = reg_req.read ? read_mux : reg_rdata;

	// event edges: a condition that simply persists cannot set a bit again
	wire [7:0] event_rise = event_conditions & ~condition_last;

	genvar bit_index;
	generate
		for (bit_index = 0; bit_index < `EVENT_COUNT; bit_index++) begin : g_status
			// write one clears; a same-cycle event wins over the clear
			assign next_status[bit_index] = event_rise[bit_index] ||
				(interrupt_event_status[bit_index] &&
				!(status_clear && reg_req.wdata[bit_index]));
		end
	endgenerate

	// interrupt request in either mode; only whole-hub suspend is an input,
	// so per-port selective suspend cannot reach the pin
	wire general_request = |(interrupt_event_status & interrupt_event_mask);
	wire level_request   = !hub_configured || hub_suspended;
	wire next_int_oe     = suspend_indication_select ? level_request
		: general_request;

	// stage sequencing: a raised attach request overrides the connect hold bit
	always_comb begin
		next_stage = stage;
		case (stage)
			hub_sideband_pkg::STAGE_INIT: begin
				next_stage = hub_sideband_pkg::STAGE_WAIT_CONNECT;
			end
			hub_sideband_pkg::STAGE_WAIT_CONNECT: begin
				if (attach_request || !connect_hold) begin
					next_stage = hub_sideband_pkg::STAGE_COMM;
				end
			end
			hub_sideband_pkg::STAGE_COMM: begin
				next_stage = hub_sideband_pkg::STAGE_COMM;
			end
			default: begin
				next_stage = hub_sideband_pkg::STAGE_INIT;
			end
		endcase
	end

	// straps are read in the init stage only; later changes are ignored
	wire [1:0] next_ref_sel = (stage == hub_sideband_pkg::STAGE_INIT) ?
		ref_select_strap : ref_frequency_select;
	wire       next_comm    = next_stage == hub_sideband_pkg::STAGE_COMM;

	// unused interlock and config bits are dropped on write so they read back 0
	wire [7:0] next_mask      = write_mask ? reg_req.wdata : interrupt_event_mask;
	wire [7:0] next_interlock = write_interlock ?
		(reg_req.wdata & `INTERLOCK_WRITE_MASK) : interlock_register;
	wire [7:0] next_cfg       = write_cfg ?
		(reg_req.wdata & `SIDEBAND_CFG_WRITE_MASK) : sideband_cfg;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stage      <= hub_sideband_pkg::STAGE_INIT;
			comm_stage <= 1'b0;
		end else begin
			stage      <= next_stage;
			comm_stage <= next_comm;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			interrupt_event_status <= `EVENT_STATUS_RESET;
			condition_last         <= `EVENT_STATUS_RESET;
		end else begin
			interrupt_event_status <= next_status;
			condition_last         <= event_conditions;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			interrupt_event_mask <= `EVENT_MASK_RESET;
		end else begin
			interrupt_event_mask <= next_mask;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			interlock_register <= `INTERLOCK_RESET;
		end else begin
			interlock_register <= next_interlock;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sideband_cfg <= `SIDEBAND_CFG_RESET;
		end else begin
			sideband_cfg <= next_cfg;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ref_frequency_select <= `REF_SEL_RESET;
		end else begin
			ref_frequency_select <= next_ref_sel;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			reg_rdata <= `READ_DATA_RESET;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// the pin is open drain: only the enable moves, the drive value stays low
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			int_pin_out <= 1'b0;
			int_pin_oe  <= 1'b0;
		end else begin
			int_pin_out <= 1'b0;
			int_pin_oe  <= next_int_oe;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	attach_enter_a: assert property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT && attach_request
		|=> stage == hub_sideband_pkg::STAGE_COMM ##1 comm_stage)
		else $error("attach request did not enter communication stage");

	hold_wait_a: assert property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT && !attach_request && connect_hold
		|=> stage == hub_sideband_pkg::STAGE_WAIT_CONNECT)
		else $error("left wait stage while connect hold set");

	hold_release_a: assert property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT && !connect_hold
		|=> stage == hub_sideband_pkg::STAGE_COMM)
		else $error("connect hold clear did not enter communication");

	strap_held_a: assert property (
		stage != hub_sideband_pkg::STAGE_INIT |=> $stable(ref_frequency_select))
		else $error("strap value changed after initialisation");

	event_latch_a: assert property (
		event_conditions[0] && !condition_last[0]
		|=> interrupt_event_status[0])
		else $error("rising condition did not set status bit");

	status_sticky_a: assert property (
		interrupt_event_status[0] && !(status_clear && reg_req.wdata[0])
		|=> interrupt_event_status[0])
		else $error("status bit lost without a clear");

	persist_no_set_a: assert property (
		!interrupt_event_status[0] && condition_last[0]
		|=> !interrupt_event_status[0])
		else $error("persisting condition set status bit again");

	general_pin_a: assert property (
		!suspend_indication_select ##1 !$past(suspend_indication_select)
		|-> int_pin_oe == $past(general_request))
		else $error("general interrupt pin mismatches status and mask");

	level_pin_a: assert property (
		suspend_indication_select |=> int_pin_oe == $past(level_request))
		else $error("level interrupt pin mismatches suspend state");

	reset_clear_a: assert property (
		!$past(rst_b) |-> interrupt_event_status == `EVENT_STATUS_RESET
		&& interrupt_event_mask == `EVENT_MASK_RESET && !suspend_indication_select)
		else $error("reset left interrupt state set");

	attach_auto_a: assert property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT && attach_request && connect_hold
		|=> comm_stage)
		else $error("raised attach did not override connect hold");

	attach_rise_a: assert property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT && $rose(attach_request)
		|=> stage == hub_sideband_pkg::STAGE_COMM)
		else $error("attach rising edge did not enter communication");

	comm_hold_a: assert property (
		comm_stage |=> comm_stage)
		else $error("communication stage left without reset");

	strap_capture_a: assert property (
		stage == hub_sideband_pkg::STAGE_INIT
		|=> ref_frequency_select == $past(ref_select_strap))
		else $error("strap not captured in init stage");

	mask_write_a: assert property (
		write_mask |=> interrupt_event_mask == $past(reg_req.wdata))
		else $error("mask write did not land");

	status_clear_a: assert property (
		status_clear && reg_req.wdata[0] && !event_rise[0]
		|=> !interrupt_event_status[0])
		else $error("status bit not cleared by write");

	read_status_a: assert property (
		reg_req.read && hit_status |=> reg_rdata == $past(interrupt_event_status))
		else $error("status read returned wrong value");

	rdata_hold_a: assert property (
		!reg_req.read |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	general_assert_a: assert property (
		!suspend_indication_select && general_request |=> int_pin_oe)
		else $error("enabled status did not pull interrupt low");

	level_suspend_a: assert property (
		suspend_indication_select && hub_suspended |=> int_pin_oe)
		else $error("hub suspend not indicated on pin");

	level_active_a: assert property (
		suspend_indication_select && hub_configured && !hub_suspended |=> !int_pin_oe)
		else $error("active configured hub held pin low");

	comm_reached_c: cover property (
		stage == hub_sideband_pkg::STAGE_WAIT_CONNECT ##1 stage == hub_sideband_pkg::STAGE_COMM);
	general_int_c: cover property (!suspend_indication_select ##1 int_pin_oe ##[1:20] !int_pin_oe);
	level_int_c: cover property (suspend_indication_select && int_pin_oe);
	set_over_clear_c: cover property (status_clear && reg_req.wdata[0] && event_rise[0]);

endmodule : hub_interrupt_connect_control

// [core/hub_sideband_consts.svh]
// constants of the hub sideband control block: register indexes, fields, resets
// assumes the serial port engine presents byte addresses of the register space
`ifndef HUB_SIDEBAND_CONSTS_SVH
`define HUB_SIDEBAND_CONSTS_SVH

`define EVENT_STATUS_ADDR   8'hE8
`define EVENT_MASK_ADDR     8'hE9
`define INTERLOCK_ADDR      8'hE7
`define SIDEBAND_CFG_ADDR   8'hE6

`define CONNECT_HOLD_BIT    0
`define SUSPEND_SELECT_BIT  0

`define INTERLOCK_WRITE_MASK    8'h01
`define SIDEBAND_CFG_WRITE_MASK 8'h01

`define EVENT_STATUS_RESET  8'h00
`define EVENT_MASK_RESET    8'h00
`define INTERLOCK_RESET     8'h01
`define SIDEBAND_CFG_RESET  8'h00
`define READ_DATA_RESET     8'h00

`define REF_SEL_38M4        2'h0
`define REF_SEL_26M0        2'h1
`define REF_SEL_19M2        2'h2
`define REF_SEL_12M0        2'h3
`define REF_SEL_RESET       2'h0

`define EVENT_COUNT         8

`endif

// [core/hub_sideband_pkg.sv]
// types of the hub sideband control block
// assumes hub_sideband_consts.svh is included beside it
`include "hub_sideband_consts.svh"

package hub_sideband_pkg;

	typedef enum logic [1:0] {
		STAGE_INIT,
		STAGE_WAIT_CONNECT,
		STAGE_COMM
	} hub_stage_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} reg_req_s;

	typedef logic [`EVENT_COUNT-1:0] event_vec_t;

endpackage : hub_sideband_pkg

// [dv/hub_system_model.sv]
// processor side model: drives the attach pin and the clock straps
// assumes the bench states what it wants on each pin
`timescale 1ns/1ns

module hub_system_model (
	input  wire logic       rst_b,
	input  wire logic       attach_want,
	input  wire logic [1:0] strap_want,
	output logic            attach_request,
	output logic [1:0]      ref_select_strap
);
	// attach is gated so it never rises while reset holds the hub in standby
	assign attach_request   = attach_want & rst_b;
	assign ref_select_strap = strap_want;
endmodule : hub_system_model

// [dv/hub_interrupt_connect_control_tb.sv]
// self-checking bench: straps, attach stage, latched events, level mode
// assumes hub_system_model drives the attach pin and the straps
`timescale 1ns/1ns
`include "hub_sideband_consts.svh"

module hub_interrupt_connect_control_tb;
	logic                         clock;
	logic                         rst_b;
	logic                         attach_want;
	logic [1:0]                   strap_want;
	logic                         attach_request;
	logic [1:0]                   ref_select_strap;
	hub_sideband_pkg::event_vec_t event_conditions;
	logic                         hub_configured;
	logic                         hub_suspended;
	hub_sideband_pkg::reg_req_s   reg_req;
	logic [7:0]                   reg_rdata;
	logic [1:0]                   ref_frequency_select;
	logic                         comm_stage;
	logic                         int_pin_out;
	logic                         int_pin_oe;
	int                           fails;
	int                           num_checks;
	int                           st;
	int                           msk;
	logic [31:0]                  seed;
	logic [7:0]                   rd;
	logic [7:0]                   v;

	hub_system_model hub_system_model_inst (.rst_b(rst_b), .attach_want(attach_want),
		.strap_want(strap_want), .attach_request(attach_request),
		.ref_select_strap(ref_select_strap));

	hub_interrupt_connect_control hub_interrupt_connect_control_inst (.clock(clock),
		.rst_b(rst_b), .attach_request(attach_request), .ref_select_strap(ref_select_strap),
		.event_conditions(event_conditions), .hub_configured(hub_configured),
		.hub_suspended(hub_suspended), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.ref_frequency_select(ref_frequency_select), .comm_stage(comm_stage),
		.int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one-cycle request pulse, released at the next falling edge
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clock);
		reg_req = '{a, d, 1'b1, 1'b0};
		@(negedge clock);
		reg_req = '0;
	endtask : wr

	task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_req = '{a, 8'h00, 1'b0, 1'b1};
		@(negedge clock);
		reg_req = '0;
		d = reg_rdata;
	endtask : rd_reg

	task automatic do_reset(logic [1:0] s, logic a);
		strap_want = s;
		attach_want = a;
		rst_b = 1'b0;
		repeat (6) @(negedge clock);
		rst_b = 1'b1;
		@(negedge clock);
	endtask : do_reset

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		#100000;
		fails++;
		report_and_stop();
	end

	initial begin
		seed = 79;
		fails = 0;
		num_checks = 0;
		event_conditions = '0;
		hub_configured = 1'b0;
		hub_suspended = 1'b0;
		reg_req = '0;
		// every strap code, alternating the two ways into the communication stage
		for (int i = 0; i < 4; i++) begin
			// the third pass keeps attach high through reset: the tied-high case
			do_reset(i[1:0], i == 2);
			chk("strap", 8'(i), 8'(ref_frequency_select));
			strap_want = ~strap_want;
			rd_reg(`EVENT_MASK_ADDR, rd);
			chk("mask reset", 8'h00, rd);
			rd_reg(8'h10, rd);
			chk("unmapped", 8'h00, rd);
			chk("strap held", 8'(i), 8'(ref_frequency_select));
			if (i[0]) begin
				chk("held off", 8'h00, 8'(comm_stage));
				wr(`INTERLOCK_ADDR, 8'h00);
				@(negedge clock);
				chk("comm by hold", 8'h01, 8'(comm_stage));
				rd_reg(`INTERLOCK_ADDR, rd);
				chk("interlock", 8'h00, rd);
			end else begin
				attach_want = 1'b1;
				repeat (2) @(negedge clock);
				chk("comm by attach", 8'h01, 8'(comm_stage));
			end
		end
		msk = xs() & 255;
		wr(`EVENT_MASK_ADDR, msk[7:0]);
		rd_reg(`EVENT_MASK_ADDR, rd);
		chk("mask", msk[7:0], rd);
		st = 0;
		for (int n = 0; n < 40; n++) begin
			v = 8'(xs());
			st = st | (v & ~event_conditions);
			event_conditions = v;
			repeat (2) @(negedge clock);
			chk("int set", 8'(|(st & msk)), 8'(int_pin_oe));
			rd_reg(`EVENT_STATUS_ADDR, rd);
			chk("status", st[7:0], rd);
			v = 8'(xs());
			wr(`EVENT_STATUS_ADDR, v);
			st = st & ~v;
			@(negedge clock);
			chk("int clear", 8'(|(st & msk)), 8'(int_pin_oe));
			rd_reg(`EVENT_STATUS_ADDR, rd);
			chk("no re-event", st[7:0], rd);
		end
		// a fresh event in the cycle of a clear-all write must survive it
		event_conditions = '0;
		repeat (2) @(negedge clock);
		event_conditions = 8'h01;
		reg_req = '{`EVENT_STATUS_ADDR, 8'hFF, 1'b1, 1'b0};
		@(negedge clock);
		reg_req = '0;
		rd_reg(`EVENT_STATUS_ADDR, rd);
		chk("set over clear", 8'h01, rd);
		wr(`SIDEBAND_CFG_ADDR, 8'h01);
		rd_reg(`SIDEBAND_CFG_ADDR, rd);
		chk("cfg", 8'h01, rd);
		for (int k = 0; k < 12; k++) begin
			{hub_configured, hub_suspended} = 2'(xs());
			repeat (2) @(negedge clock);
			chk("level", 8'(!hub_configured || hub_suspended), 8'(int_pin_oe));
		end
		chk("pin drive", 8'h00, 8'(int_pin_out));
		event_conditions = '0;
		do_reset(2'h3, 1'b0);
		rd_reg(`EVENT_STATUS_ADDR, rd);
		chk("status reset", 8'h00, rd);
		rd_reg(`EVENT_MASK_ADDR, rd);
		chk("mask after reset", 8'h00, rd);
		rd_reg(`SIDEBAND_CFG_ADDR, rd);
		chk("cfg reset", 8'h00, rd);
		report_and_stop();
	end
endmodule : hub_interrupt_connect_control_tb
